//--- logic/input_sync.sv
// Three-stage synchroniser for a vector of asynchronous inputs; output updates when stages agree
`timescale 1ns/1ns
module input_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_syncOut = (agree & stage3) | (~agree & syncOut);

  always_ff @(posedge refClk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= next_syncOut;
    end
  end
endmodule

//--- logic/ldo_alarm_pkg.sv
// Register map, field positions and reset values for the regulator mask and alarm status bank
package ldo_alarm_pkg;
  localparam int ADDR_W = 12;
  // Printed offsets are word indices, not byte addresses: index times four gives the byte address
  localparam logic [7:0] LDO0_7_MASK_INDEX = 8'h0b;
  localparam logic [7:0] LDO8_MASK_INDEX = 8'h0c;
  localparam logic [7:0] STATUS_INDEX = 8'h0d;
  localparam logic [7:0] EVENT_STATUS_INDEX = 8'h40;
  localparam logic [7:0] EVENT_MASK_INDEX = 8'h41;
  localparam logic [ADDR_W-1:0] LDO0_7_MASK_ADDR = {2'h0, LDO0_7_MASK_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] LDO8_MASK_ADDR = {2'h0, LDO8_MASK_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = {2'h0, EVENT_STATUS_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = {2'h0, EVENT_MASK_INDEX, 2'h0};
  localparam int LDO_COUNT = 9;
  localparam logic [7:0] LDO0_7_MASK_RESET = 8'hff;
  localparam logic [7:0] LDO8_MASK_RESET = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] EVENT_MASK_RESET = 3'h7;
  localparam int LDO8_MASK_BIT = 0;
  localparam int BATTERY_BIT = 2;
  localparam int THERMAL_LOW_BIT = 1;
  localparam int THERMAL_HIGH_BIT = 0;
  localparam int STATUS_W = 3;
endpackage

//--- logic/ldo_irq_mask_and_alarm_status.sv
// Regulator interrupt masks, battery and thermal alarm status, APB slave and alarm interrupt
`timescale 1ns/1ns
module ldo_irq_mask_and_alarm_status (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ldo_alarm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Regulator event inputs, one per regulator, level high while the event stands
  input wire logic [ldo_alarm_pkg::LDO_COUNT-1:0] regulatorEvent,
  // Comparator inputs from the analog side, asynchronous
  input wire logic batteryBelowReset,
  input wire logic thermalAboveFirst,
  input wire logic thermalAboveSecond,
  // Interrupt outputs
  output logic interrupt_out_n,
  output logic alarmIrq
);
  // Mask registers, written by software
  logic [7:0] ldoMaskLow;
  logic regulator8_event_mask;
  logic [ldo_alarm_pkg::STATUS_W-1:0] eventMask;

  // Alarm event flags and the level they were raised from
  logic [ldo_alarm_pkg::STATUS_W-1:0] eventStatus;
  logic [ldo_alarm_pkg::STATUS_W-1:0] prevStatus;

  // Pin levels after the synchronisers
  logic [ldo_alarm_pkg::STATUS_W-1:0] liveStatus;
  logic [ldo_alarm_pkg::LDO_COUNT-1:0] eventSync;
  logic irqLow;

  // Full address compare, so aliases never hit
  function automatic logic hit(input logic [ldo_alarm_pkg::ADDR_W-1:0] a,
                               input logic [ldo_alarm_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // True when a requesting bit finds its mask bit clear
  function automatic logic anyUnmasked(
    input logic [ldo_alarm_pkg::LDO_COUNT-1:0] request,
    input logic [ldo_alarm_pkg::LDO_COUNT-1:0] mask
  );
    anyUnmasked = |(request & ~mask);
  endfunction

  // Comparator levels come from the analog side with no clock relation
  input_sync #(.WIDTH(ldo_alarm_pkg::STATUS_W)) statusSync (
    .refClk(ref_clk),
    .rst(rst),
    .asyncIn({batteryBelowReset, thermalAboveFirst, thermalAboveSecond}),
    .syncOut(liveStatus)
  );

  // Regulator events are unclocked levels as well
  input_sync #(.WIDTH(ldo_alarm_pkg::LDO_COUNT)) eventPins (
    .refClk(ref_clk),
    .rst(rst),
    .asyncIn(regulatorEvent),
    .syncOut(eventSync)
  );

  // Bus decode
  wire access = psel & penable;
  wire writeLane0 = access & pwrite & pstrb[0];
  // Read data loads in the setup cycle so it stands through the access cycle
  wire setupRead = psel & ~penable & ~pwrite;
  wire selLow = hit(paddr, ldo_alarm_pkg::LDO0_7_MASK_ADDR);
  wire selL8 = hit(paddr, ldo_alarm_pkg::LDO8_MASK_ADDR);
  wire selStatus = hit(paddr, ldo_alarm_pkg::STATUS_ADDR);
  wire selEvt = hit(paddr, ldo_alarm_pkg::EVENT_STATUS_ADDR);
  wire selEvtMask = hit(paddr, ldo_alarm_pkg::EVENT_MASK_ADDR);
  wire mapped = selLow | selL8 | selStatus | selEvt | selEvtMask;

  // Status ignores writes; a write there is still acknowledged without error
  wire wrLow = writeLane0 & selLow;
  wire wrL8 = writeLane0 & selL8;
  wire wrEvt = writeLane0 & selEvt;
  wire wrEvtMask = writeLane0 & selEvtMask;

  // Live comparator levels in their register positions
  wire batteryLow = liveStatus[ldo_alarm_pkg::BATTERY_BIT];
  wire thermalFirst = liveStatus[ldo_alarm_pkg::THERMAL_LOW_BIT];
  wire thermalSecond = liveStatus[ldo_alarm_pkg::THERMAL_HIGH_BIT];
  wire [ldo_alarm_pkg::STATUS_W-1:0] statusBits;
  assign statusBits[ldo_alarm_pkg::BATTERY_BIT] = batteryLow;
  assign statusBits[ldo_alarm_pkg::THERMAL_LOW_BIT] = thermalFirst;
  assign statusBits[ldo_alarm_pkg::THERMAL_HIGH_BIT] = thermalSecond;
  wire [31:0] statusWord = {29'h0, statusBits};

  // Unused upper bits of each word read as 0
  wire [31:0] readMux =
    selLow ? {24'h0, ldoMaskLow} :
    selL8 ? {31'h0, regulator8_event_mask} :
    selStatus ? statusWord :
    selEvt ? {29'h0, eventStatus} :
    selEvtMask ? {29'h0, eventMask} : 32'h0;

  // Rising alarm edges are the interrupt events; set beats clear
  wire [ldo_alarm_pkg::STATUS_W-1:0] risen = liveStatus & ~prevStatus;
  wire [ldo_alarm_pkg::STATUS_W-1:0] clearBits =
    wrEvt ? pwdata[ldo_alarm_pkg::STATUS_W-1:0] : 3'h0;
  wire [ldo_alarm_pkg::STATUS_W-1:0] next_eventStatus = (eventStatus & ~clearBits) | risen;

  // Regulator events pull the pin as levels, since no flag register is kept
  wire [ldo_alarm_pkg::LDO_COUNT-1:0] allMask = {regulator8_event_mask, ldoMaskLow};
  wire next_irqLow = anyUnmasked(eventSync, allMask);

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // Unmapped addresses answer with an error and writes there are dropped
  assign pslverr = access & ~mapped;
  assign alarmIrq = anyUnmasked({6'h0, eventStatus}, {6'h0, eventMask});
  assign interrupt_out_n = ~irqLow;

  // Masks of regulators zero to seven
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ldoMaskLow <= ldo_alarm_pkg::LDO0_7_MASK_RESET;
    end
    else if (wrLow)
    begin
      ldoMaskLow <= pwdata[7:0];
    end
  end

  // Mask of regulator eight, masked out of reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      regulator8_event_mask <= ldo_alarm_pkg::LDO8_MASK_RESET[ldo_alarm_pkg::LDO8_MASK_BIT];
    end
    else if (wrL8)
    begin
      regulator8_event_mask <= pwdata[ldo_alarm_pkg::LDO8_MASK_BIT];
    end
  end

  // Mask of the alarm event flags
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      eventMask <= ldo_alarm_pkg::EVENT_MASK_RESET;
    end
    else if (wrEvtMask)
    begin
      eventMask <= pwdata[ldo_alarm_pkg::STATUS_W-1:0];
    end
  end

  // Previous live level for edge detection; zero matches the idle comparator
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prevStatus <= '0;
    end
    else
    begin
      prevStatus <= liveStatus;
    end
  end

  // Sticky alarm event flags, write one to clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      eventStatus <= '0;
    end
    else
    begin
      eventStatus <= next_eventStatus;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
    end
    else if (setupRead)
    begin
      prdata <= readMux;
    end
  end

  // Registered interrupt pin drive
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irqLow <= 1'b0;
    end
    else
    begin
      irqLow <= next_irqLow;
    end
  end
endmodule

//--- verif/host_model.sv
// Host APB master model
`timescale 1ns/1ns
module host_model (
  // Bus
  input wire logic ref_clk, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 0, penable = 0, pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0
);
  int timeouts = 0;
  // One transfer; read data and error are taken at the edge that sees pready high
  task automatic x(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 9);
    if (pready !== 1'b1)
      timeouts++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge ref_clk);
  endtask
endmodule

//--- verif/ldo_alarm_monitor.sv
// Assertions on the bank's ports
`timescale 1ns/1ns
module ldo_alarm_monitor (
  // Watched ports
  input wire logic ref_clk, rst, psel, penable, pwrite, pslverr, interrupt_out_n, alarmIrq,
  input wire logic batteryBelowReset, thermalAboveFirst, thermalAboveSecond,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [8:0] regulatorEvent
);
  wire logic [2:0] c = {batteryBelowReset, thermalAboveFirst, thermalAboveSecond};
  wire logic rs = psel && penable && !pwrite && paddr == 12'h034;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_QUIET: assert property ((regulatorEvent == 0) [*6] |-> interrupt_out_n)
    else $error("irq low");
  AST_STAT: assert property ($stable(c) [*8] ##0 rs |-> prdata[2:0] == c)
    else $error("status bits");
  AST_NOERR: assert property (psel && penable && paddr == 12'h034 |-> !pslverr)
    else $error("status refused");
  AST_RST: assert property ($fell(rst) |-> interrupt_out_n && !alarmIrq && prdata == 0)
    else $error("reset outputs");
  AST_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  AST_UNMAP: assert property (psel && penable && paddr == 12'h200 |-> pslverr)
    else $error("no error");
  cover property (rs);
  cover property (!interrupt_out_n);
  cover property (alarmIrq);
endmodule
bind ldo_irq_mask_and_alarm_status ldo_alarm_monitor mon (.*);

//--- verif/tb_ldo_irq_mask_and_alarm_status.sv
// Bench for the mask and alarm status bank
`timescale 1ns/1ns
module tb_ldo_irq_mask_and_alarm_status;
  logic ref_clk = 0, rst = 1, psel, penable, pwrite, pready, pslverr, alarmIrq, e;
  logic interrupt_out_n, batteryBelowReset = 0, thermalAboveFirst = 0, thermalAboveSecond = 0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r = 32'hf78280d1;
  logic [8:0] regulatorEvent = 0;
  logic [3:0] pstrb = 4'hf;
  int miscompares = 0, n_compared = 0;
  int mLow = 255, m8 = 1;
  host_model host (.*);
  ldo_irq_mask_and_alarm_status dut (.*);
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  task chk(input logic [31:0] got, input int want);
    n_compared++;
    if (got !== want)
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    miscompares += int'(got !== want);
  endtask
  task rd(input logic [11:0] a, input int want, input logic [7:0] m);
    host.x(0, a, 0, q, e);
    chk(q & m, want);
  endtask
  task report_and_stop(input int extra);
    miscompares += extra + host.timeouts;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  initial #400000 report_and_stop(1);
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    rd(12'h02c, mLow, 255);
    rd(12'h030, m8, 1);
    rd(12'h200, 0, 255);
    chk(e, 1);
    repeat (20)
    begin
      r = lf(r);
      {regulatorEvent, batteryBelowReset, thermalAboveFirst, thermalAboveSecond} <= r[20:9];
      host.x(1, 12'h02c, r[7:0], q, e);
      host.x(1, 12'h030, r[8], q, e);
      host.x(1, 12'h034, r[23:21], q, e);
      mLow = r[7:0];
      m8 = r[8];
      repeat (4) @(posedge ref_clk);
      chk(interrupt_out_n, (r[20:12] & ~{m8[0], mLow[7:0]}) == 0);
      rd(12'h02c, mLow, 255);
      rd(12'h030, m8, 1);
      rd(12'h034, r[11:9], 7);
    end
    regulatorEvent <= 9'h000;
    {batteryBelowReset, thermalAboveFirst, thermalAboveSecond} <= 3'h0;
    host.x(1, 12'h104, 0, q, e);
    host.x(1, 12'h100, 7, q, e);
    chk(alarmIrq, 0);
    thermalAboveFirst <= 1;
    repeat (8) @(posedge ref_clk);
    chk(alarmIrq, 1);
    host.x(1, 12'h104, 7, q, e);
    chk(alarmIrq, 0);
    host.x(1, 12'h100, 2, q, e);
    rd(12'h100, 0, 7);
    report_and_stop(0);
  end
endmodule
